/* rtl/hfb_fifo.sv */
// host fifo: 64 byte shared buffer, apb registers, receive packet admission
//
// Functional notes
// [RQ1] one 64-byte buffer shared by both directions
// [RQ2] host data write stores byte, advances write pointer
// [RQ3] host data read returns byte, advances read pointer
// [RQ4] seven-bit level shows stored byte count
// [RQ5] internal command logic reads/writes same buffer
// [RQ6] host avoids buffer access during running commands
// [RQ7] flush resets pointers, level and overflow
// [RQ8] overflow cleared only by flush
// [RQ9] excess received data lost, overflow set
// [RQ10] almost full when free space <= threshold
// [RQ11] almost empty when count <= threshold
// [RQ12] almost-empty rise raises enabled interrupt
// [RQ13] almost-full rise raises enabled interrupt
// [RQ14] continuous receive accepts packets back to back; code needs one idle cycle between packets, else the next length byte is lost
// [RQ15] continuous receive appends one status byte
// [RQ16] first packet byte is length, stored first
// [RQ17] reject length below minimum times four
// [RQ18] accept length below maximum times four; zero=256
// [RQ19] rejected packet not stored, reception stays active
// [RQ20] any new error bit raises error interrupt flag
// [RQ21] host write when full dropped, overflow set
// [RQ22] host read when empty changes nothing
`timescale 1ns/1ps
`default_nettype none

module hfb_fifo #(
  parameter int DEPTH = hfb_pkg::DEPTH
) (
  input  wire logic                MCLK_I,
  input  wire logic                RESET_N_I,
  input  wire logic                PSEL_I,
  input  wire logic                PENABLE_I,
  input  wire logic                PWRITE_I,
  input  wire logic [7:0]          PADDR_I,
  input  wire logic [31:0]         PWDATA_I,
  output var  logic [31:0]         PRDATA_O,
  output var  logic                PREADY_O,
  output var  logic                PSLVERR_O,
  input  wire hfb_pkg::hfb_rx_type RX_I,
  input  wire hfb_pkg::hfb_cmd_type CMD_I,
  output var  logic [7:0]          CMD_RDATA_O,
  output var  logic                CMD_RVALID_O,
  output var  logic                RX_ACTIVE_O,
  output var  logic                IRQ_O
);

  localparam int PW = $clog2(DEPTH);
  // count is one bit wider than the pointers so full and empty differ
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  // buffer storage and pointers
  logic [7:0]    mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr;
  logic [PW-1:0] rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;

  // software visible state
  logic          overflow, next_overflow;
  logic [6:0]    rx_err, next_rx_err;
  logic [5:0]    thresh, next_thresh;
  logic [2:0]    irq_en, next_irq_en;
  logic [2:0]    irq_flag, next_irq_flag;
  logic          rx_enable, next_rx_enable;
  logic          rx_cont, next_rx_cont;
  logic [5:0]    len_min, next_len_min;
  logic [5:0]    len_max, next_len_max;
  logic          almost_full, next_almost_full;
  logic          almost_empty, next_almost_empty;

  // receiver admission state
  hfb_pkg::hfb_rx_state_type rx_state, next_rx_state;
  logic          status_pend, next_status_pend;
  logic [7:0]    status_byte, next_status_byte;

  // bus and command answers
  logic [31:0]   prdata, next_prdata;
  logic          pready, next_pready;
  logic          pslverr, next_pslverr;
  logic [7:0]    cmd_rdata, next_cmd_rdata;
  logic          cmd_rvalid, next_cmd_rvalid;
  logic          irq_out, next_irq_out;

  // combinational helpers
  logic          host_acc, host_go, host_wr, host_rd;
  logic          sel_data, sel_level, mapped;
  logic          rx_wr;
  logic [7:0]    rx_byte;
  logic          len_ok;
  logic          wr_req, wr_eff, wr_lost, rd_eff, flush;
  logic [7:0]    wr_byte;
  logic [1:0]    n_int_wr;

  // apb decode; an access phase is served once, then pready answers
  always_comb begin
    host_acc  = PSEL_I && PENABLE_I && !pready;
    sel_data  = (PADDR_I == hfb_pkg::OFF_DATA);
    sel_level = (PADDR_I == hfb_pkg::OFF_LEVEL);
    mapped    = sel_data || sel_level
             || (PADDR_I == hfb_pkg::OFF_THRESH)   || (PADDR_I == hfb_pkg::OFF_STATUS)
             || (PADDR_I == hfb_pkg::OFF_ERROR)    || (PADDR_I == hfb_pkg::OFF_IRQ_EN)
             || (PADDR_I == hfb_pkg::OFF_IRQ_FLAG) || (PADDR_I == hfb_pkg::OFF_RX_MODE)
             || (PADDR_I == hfb_pkg::OFF_LEN_LOW)  || (PADDR_I == hfb_pkg::OFF_LEN_HIGH);
  end

  // length window: min*4 <= len < max*4, max of zero means 256
  // checked on the length byte itself, so a rejected packet never takes space
  always_comb begin
    len_ok = (RX_I.data >= {len_min, 2'b00})                          // RQ17
          && ((len_max == 6'h00) || (RX_I.data < {len_max, 2'b00}));  // RQ18
  end

  // receive admission: length byte decides whether the packet enters
  // a byte arriving while the status byte is written is lost as an overflow
  always_comb begin
    next_rx_state    = rx_state;
    next_status_pend = 1'b0;
    next_status_byte = status_byte;
    rx_wr            = 1'b0;
    rx_byte          = RX_I.data;
    case (rx_state)
      hfb_pkg::RX_LEN: begin
        if (RX_I.valid && rx_enable) begin
          if (len_ok) begin
            rx_wr = 1'b1;                                          // RQ16
            if (!RX_I.last) begin
              next_rx_state = hfb_pkg::RX_BODY;
            end
          end else if (!RX_I.last) begin
            next_rx_state = hfb_pkg::RX_DROP;                      // RQ19
          end
        end
      end
      hfb_pkg::RX_BODY: begin
        if (RX_I.valid) begin
          rx_wr = 1'b1;
          if (RX_I.last) begin
            next_rx_state = hfb_pkg::RX_LEN;
          end
        end
      end
      hfb_pkg::RX_DROP: begin
        // discarded bytes never touch the buffer; receiver stays armed
        if (RX_I.valid && RX_I.last) begin
          next_rx_state = hfb_pkg::RX_LEN;                         // RQ19
        end
      end
      default: begin
        next_rx_state = hfb_pkg::RX_LEN;
      end
    endcase
    // end of a stored packet in continuous mode queues the status byte
    if (rx_wr && RX_I.last) begin
      if (rx_cont) begin
        next_status_pend = 1'b1;                                   // RQ15
        next_status_byte = {1'b0, RX_I.err};
      end
    end
  end

  // buffer arbitration: status byte, receiver, command, then host
  // internal writers are not expected to collide; if two strobe in one
  // cycle only the highest-priority byte is kept and the loss counts as
  // an overflow, so software still sees that data went missing
  always_comb begin
    n_int_wr = {1'b0, status_pend} + {1'b0, rx_wr} + {1'b0, CMD_I.wr};
    // the host waits rather than collide with internal traffic
    host_go  = host_acc
            && !(PWRITE_I && sel_data && (n_int_wr != 2'd0))
            && !(!PWRITE_I && sel_data && CMD_I.rd);               // RQ6
    host_wr  = host_go && PWRITE_I && sel_data;
    host_rd  = host_go && !PWRITE_I && sel_data;
    flush    = host_go && PWRITE_I && sel_level && PWDATA_I[hfb_pkg::FLUSH_BIT];
    wr_req   = (n_int_wr != 2'd0) || host_wr;
    if (status_pend) begin
      wr_byte = status_byte;
    end else if (rx_wr) begin
      wr_byte = rx_byte;
    end else if (CMD_I.wr) begin
      wr_byte = CMD_I.wdata;                                       // RQ5
    end else begin
      wr_byte = PWDATA_I[7:0];                                     // RQ2
    end
    // a full buffer or two internal writes at once lose data
    wr_lost  = (wr_req && (count == FULL_COUNT)) || (n_int_wr > 2'd1);   // RQ9 RQ21
    wr_eff   = wr_req && (count != FULL_COUNT) && !flush;
    rd_eff   = (CMD_I.rd || host_rd) && (count != '0) && !flush;  // RQ22
  end

  // pointers, level and overflow
  // a write and a read in one cycle leave the level where it was
  always_comb begin
    next_wr_ptr   = wr_ptr + PW'(wr_eff);                          // RQ2
    next_rd_ptr   = rd_ptr + PW'(rd_eff);                          // RQ3
    next_count    = count + CW'(wr_eff) - CW'(rd_eff);             // RQ4
    next_overflow = overflow;
    if (flush) begin
      next_wr_ptr   = '0;                                          // RQ7
      next_rd_ptr   = '0;
      next_count    = '0;
      next_overflow = 1'b0;
    end
    // a loss in the flush cycle still leaves the flag set
    if (wr_lost) begin
      next_overflow = 1'b1;                                        // RQ8 RQ9 RQ21
    end
  end

  // watermark alerts follow the next level
  // using the next level keeps alerts and interrupts in step with the count
  always_comb begin
    next_almost_full  = ((FULL_COUNT - next_count) <= CW'(thresh));  // RQ10
    next_almost_empty = (next_count <= CW'(thresh));               // RQ11
  end

  // configuration writes, interrupt flags and the receiver enable
  always_comb begin
    next_thresh    = thresh;
    next_irq_en    = irq_en;
    next_irq_flag  = irq_flag;
    next_rx_enable = rx_enable;
    next_rx_cont   = rx_cont;
    next_len_min   = len_min;
    next_len_max   = len_max;
    next_rx_err    = rx_err;
    // single packet mode: reception ends after one stored packet
    if (rx_wr && RX_I.last && !rx_cont) begin
      next_rx_enable = 1'b0;
    end
    if (host_go && PWRITE_I) begin
      case (PADDR_I)
        hfb_pkg::OFF_THRESH:   next_thresh  = PWDATA_I[5:0];
        hfb_pkg::OFF_IRQ_EN:   next_irq_en  = PWDATA_I[2:0];
        hfb_pkg::OFF_IRQ_FLAG: next_irq_flag = irq_flag & ~PWDATA_I[2:0];
        hfb_pkg::OFF_ERROR:    next_rx_err  = rx_err & ~PWDATA_I[7:1];
        hfb_pkg::OFF_RX_MODE: begin
          next_rx_enable = PWDATA_I[hfb_pkg::RXM_ENABLE_BIT];      // RQ14
          next_rx_cont   = PWDATA_I[hfb_pkg::RXM_CONT_BIT];
        end
        hfb_pkg::OFF_LEN_LOW:  next_len_min = PWDATA_I[5:0];
        hfb_pkg::OFF_LEN_HIGH: next_len_max = PWDATA_I[5:0];
        default: begin
        end
      endcase
    end
    // packet error bits latch after the clear, so a same-cycle error survives
    if (rx_wr && RX_I.last) begin
      next_rx_err = next_rx_err | RX_I.err;
    end
    // hardware sets come after the clear so a same-cycle event survives
    if (irq_en[hfb_pkg::IRQ_LO_BIT] && next_almost_empty && !almost_empty) begin
      next_irq_flag[hfb_pkg::IRQ_LO_BIT] = 1'b1;                   // RQ12
    end
    if (irq_en[hfb_pkg::IRQ_HI_BIT] && next_almost_full && !almost_full) begin
      next_irq_flag[hfb_pkg::IRQ_HI_BIT] = 1'b1;                   // RQ13
    end
    if (({next_rx_err, next_overflow} & ~{rx_err, overflow}) != 8'h00) begin
      next_irq_flag[hfb_pkg::IRQ_ERR_BIT] = 1'b1;                  // RQ20
    end
  end

  // bus answers and internal read data
  // pready is held off for one cycle after each answer, so no access is served twice
  always_comb begin
    next_pready     = host_go;
    next_pslverr    = host_go && !mapped;
    next_prdata     = prdata;
    next_cmd_rvalid = CMD_I.rd && rd_eff;
    next_cmd_rdata  = (CMD_I.rd && rd_eff) ? mem[rd_ptr] : cmd_rdata;   // RQ5
    next_irq_out    = ((next_irq_flag & next_irq_en) != 3'h0);
    if (host_go && !PWRITE_I) begin
      case (PADDR_I)
        hfb_pkg::OFF_DATA:     next_prdata = {24'h0, (count != '0) ? mem[rd_ptr] : 8'h00};  // RQ3
        hfb_pkg::OFF_LEVEL:    next_prdata = {25'h0, LEVEL_PAD(count)};   // RQ4
        hfb_pkg::OFF_THRESH:   next_prdata = {26'h0, thresh};
        hfb_pkg::OFF_STATUS:   next_prdata = {29'h0, rx_enable, almost_full, almost_empty};
        hfb_pkg::OFF_ERROR:    next_prdata = {24'h0, rx_err, overflow};
        hfb_pkg::OFF_IRQ_EN:   next_prdata = {29'h0, irq_en};
        hfb_pkg::OFF_IRQ_FLAG: next_prdata = {29'h0, irq_flag};
        hfb_pkg::OFF_RX_MODE:  next_prdata = {30'h0, rx_cont, rx_enable};
        hfb_pkg::OFF_LEN_LOW:  next_prdata = {26'h0, len_min};
        hfb_pkg::OFF_LEN_HIGH: next_prdata = {26'h0, len_max};
        default:               next_prdata = 32'h0;
      endcase
    end
  end

  // level field is seven bits whatever the depth parameter
  function automatic logic [6:0] LEVEL_PAD(input logic [CW-1:0] c);
    LEVEL_PAD = 7'(c);
  endfunction : LEVEL_PAD

  // buffer storage has no reset; flushed entries are simply unreachable
  // no bypass is needed: a read never targets the slot being written, since
  // equal pointers mean empty (no read) or full (no write)
  always_ff @(posedge MCLK_I) begin
    if (wr_eff) begin
      mem[wr_ptr] <= wr_byte;                                      // RQ1
    end
  end

  // state registers
  // synchronous reset only; the array stays out of it so it can map to ram
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      count        <= '0;
      overflow     <= 1'b0;
      rx_err       <= 7'h00;
      thresh       <= hfb_pkg::THRESH_RST;
      irq_en       <= hfb_pkg::IRQ_EN_RST;
      irq_flag     <= 3'h0;
      rx_enable    <= 1'b0;
      rx_cont      <= 1'b0;
      len_min      <= hfb_pkg::LEN_MIN_RST;
      len_max      <= hfb_pkg::LEN_MAX_RST;
      almost_full  <= 1'b0;
      almost_empty <= 1'b1;
      rx_state     <= hfb_pkg::RX_LEN;
      status_pend  <= 1'b0;
      status_byte  <= 8'h00;
      prdata       <= 32'h0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      cmd_rdata    <= 8'h00;
      cmd_rvalid   <= 1'b0;
      irq_out      <= 1'b0;
    end else begin
      wr_ptr       <= next_wr_ptr;
      rd_ptr       <= next_rd_ptr;
      count        <= next_count;
      overflow     <= next_overflow;
      rx_err       <= next_rx_err;
      thresh       <= next_thresh;
      irq_en       <= next_irq_en;
      irq_flag     <= next_irq_flag;
      rx_enable    <= next_rx_enable;
      rx_cont      <= next_rx_cont;
      len_min      <= next_len_min;
      len_max      <= next_len_max;
      almost_full  <= next_almost_full;
      almost_empty <= next_almost_empty;
      rx_state     <= next_rx_state;
      status_pend  <= next_status_pend;
      status_byte  <= next_status_byte;
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
      cmd_rdata    <= next_cmd_rdata;
      cmd_rvalid   <= next_cmd_rvalid;
      irq_out      <= next_irq_out;
    end
  end

  // every output straight from a flip-flop
  // rx_active mirrors the enable bit, so it also drops when software stops
  always_comb begin
    PRDATA_O     = prdata;
    PREADY_O     = pready;
    PSLVERR_O    = pslverr;
    CMD_RDATA_O  = cmd_rdata;
    CMD_RVALID_O = cmd_rvalid;
    RX_ACTIVE_O  = rx_enable;
    IRQ_O        = irq_out;
  end

endmodule : hfb_fifo

`default_nettype wire

/* rtl/hfb_pkg.sv */
// shared constants and types for the host fifo with receive packet admission
package hfb_pkg;

  // buffer geometry
  localparam int          DEPTH          = 64;
  localparam int          LEVEL_W        = 7;

  // apb register byte addresses
  localparam logic [7:0]  OFF_DATA       = 8'h00;
  localparam logic [7:0]  OFF_LEVEL      = 8'h04;
  localparam logic [7:0]  OFF_THRESH     = 8'h08;
  localparam logic [7:0]  OFF_STATUS     = 8'h0c;
  localparam logic [7:0]  OFF_ERROR      = 8'h10;
  localparam logic [7:0]  OFF_IRQ_EN     = 8'h14;
  localparam logic [7:0]  OFF_IRQ_FLAG   = 8'h18;
  localparam logic [7:0]  OFF_RX_MODE    = 8'h1c;
  localparam logic [7:0]  OFF_LEN_LOW    = 8'h20;
  localparam logic [7:0]  OFF_LEN_HIGH   = 8'h24;

  // field positions
  localparam int          FLUSH_BIT      = 7;
  localparam int          RXM_ENABLE_BIT = 0;
  localparam int          RXM_CONT_BIT   = 1;
  localparam int          ST_LO_BIT      = 0;
  localparam int          ST_HI_BIT      = 1;
  localparam int          ST_RX_BIT      = 2;
  localparam int          IRQ_LO_BIT     = 0;
  localparam int          IRQ_HI_BIT     = 1;
  localparam int          IRQ_ERR_BIT    = 2;
  localparam int          ERR_OVFL_BIT   = 0;

  // reset values
  localparam logic [5:0]  THRESH_RST     = 6'h08;
  localparam logic [5:0]  LEN_MIN_RST    = 6'h00;
  localparam logic [5:0]  LEN_MAX_RST    = 6'h00;
  localparam logic [2:0]  IRQ_EN_RST     = 3'h0;

  // receive byte stream from the contactless receiver
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic [6:0] err;
  } hfb_rx_type;

  // buffer access from the internal command state machine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } hfb_cmd_type;

  typedef enum logic [1:0] {
    RX_LEN,
    RX_BODY,
    RX_DROP
  } hfb_rx_state_type;

endpackage : hfb_pkg

/* tb/hfb_fifo_assertions.sv */
// concurrent checks on the apb, command and receive ports of the host fifo
`timescale 1ns/1ps
`default_nettype none
module hfb_fifo_chk (
  input wire logic                 MCLK_I,
  input wire logic                 RESET_N_I,
  input wire logic                 PSEL_I,
  input wire logic                 PENABLE_I,
  input wire logic                 PWRITE_I,
  input wire logic [7:0]           PADDR_I,
  input wire logic [31:0]          PWDATA_I,
  input wire logic [31:0]          PRDATA_O,
  input wire logic                 PREADY_O,
  input wire logic                 PSLVERR_O,
  input wire hfb_pkg::hfb_rx_type  RX_I,
  input wire hfb_pkg::hfb_cmd_type CMD_I,
  input wire logic                 CMD_RVALID_O,
  input wire logic                 RX_ACTIVE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // unmapped: misaligned or above the last register
  function automatic logic bad(input logic [7:0] a);
    return (a[1:0] != 2'h0) || (a > hfb_pkg::OFF_LEN_HIGH);
  endfunction : bad
  sequence s_access_start;
    PSEL_I && $rose(PENABLE_I);
  endsequence
  sequence s_rx_mode_write;
    PREADY_O && $past(PWRITE_I && PADDR_I == hfb_pkg::OFF_RX_MODE);
  endsequence
  // bound wait: conflicts with internal writes only stretch it a little
  property p_ready_soon; s_access_start |-> ##[1:20] PREADY_O; endproperty
  property p_ready_pulse; PREADY_O |-> $past(PSEL_I && PENABLE_I) ##1 !PREADY_O; endproperty
  property p_slverr; PREADY_O |-> (PSLVERR_O == bad($past(PADDR_I))); endproperty
  property p_bad_read_zero; PREADY_O && PSLVERR_O && !$past(PWRITE_I) |-> PRDATA_O == 32'h0;
  endproperty
  property p_prdata_hold; $changed(PRDATA_O) |-> PREADY_O && !$past(PWRITE_I); endproperty
  property p_cmd_rvalid; CMD_RVALID_O |-> $past(CMD_I.rd); endproperty
  property p_rx_rise;
    $rose(RX_ACTIVE_O) |-> s_rx_mode_write and $past(PWDATA_I[0]);
  endproperty
  property p_rx_fall;
    $fell(RX_ACTIVE_O) |-> $past(RX_I.valid && RX_I.last) or s_rx_mode_write;
  endproperty
  a_ready_soon: assert property (p_ready_soon)
    else $error("apb access not answered in time");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready outside access or longer than one cycle");
  a_slverr: assert property (p_slverr)
    else $error("pslverr does not match address map");
  a_bad_read_zero: assert property (p_bad_read_zero)
    else $error("unmapped read returned nonzero data");
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data changed without a read");
  a_cmd_rvalid: assert property (p_cmd_rvalid)
    else $error("command read data without a command read");
  a_rx_rise: assert property (p_rx_rise)
    else $error("receiver enabled without a mode write");
  a_rx_fall: assert property (p_rx_fall)
    else $error("receiver stopped without packet end or mode write");
endmodule : hfb_fifo_chk

bind hfb_fifo hfb_fifo_chk u_hfb_fifo_chk (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .RX_I(RX_I), .CMD_I(CMD_I), .CMD_RVALID_O(CMD_RVALID_O), .RX_ACTIVE_O(RX_ACTIVE_O));
`default_nettype wire

/* tb/hfb_fifo_tb.sv */
// self-checking bench for the host fifo with receive packet admission
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module hfb_fifo_tb;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]           paddr, cmd_rdata, v;
  logic [31:0]          pwdata, prdata, r;
  hfb_pkg::hfb_rx_type  rx;
  hfb_pkg::hfb_cmd_type cmd;
  logic                 cmd_rvalid, rx_active, irq;
  int                   err_count = 0;
  int                   checked = 0;
  int                   th;
  int                   lens[5];
  logic [7:0]           q[$];
  logic [7:0]           zaddr[6] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};

  initial forever #25 clk = ~clk;

  hfb_host_model u_hfb_host_model (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  hfb_fifo #(.DEPTH(64)) u_hfb_fifo (.MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_I(rx), .CMD_I(cmd),
    .CMD_RDATA_O(cmd_rdata), .CMD_RVALID_O(cmd_rvalid), .RX_ACTIVE_O(rx_active),
    .IRQ_O(irq));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_hfb_host_model.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_hfb_host_model.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd
  // expected {almost_full, almost_empty} for a count and threshold
  function automatic logic [1:0] alerts(input int k, input int t);
    return {(64 - k) <= t, k <= t};
  endfunction : alerts
  function automatic logic acc(input int l, input int mn, input int mx);
    return (l >= mn * 4) && (mx == 0 || l < mx * 4);
  endfunction : acc
  // one packet, bytes back to back, then two idle cycles before the next
  task automatic pkt(input int l, input int n, input logic [6:0] ev, input logic keep,
                     input logic cont);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? l[7:0] : 8'($urandom);
      @(posedge clk) rx <= {1'b1, d, i == n - 1, ev};
      if (keep && q.size() < 64) q.push_back(d);
    end
    @(posedge clk) rx <= '0;
    if (keep && cont && q.size() < 64) q.push_back({1'b0, ev});
    @(posedge clk);
  endtask : pkt
  task automatic drain();
    int n;
    n = q.size();
    rd(hfb_pkg::OFF_LEVEL);
    `CHK(r[6:0], 7'(n))
    repeat (n) begin
      v = q.pop_front();
      rd(hfb_pkg::OFF_DATA);
      `CHK(r[7:0], v)
    end
  endtask : drain
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // watchdog: the tests need far fewer cycles than this
  initial begin
    #(50 * 80000);
    err_count++;
    print_verdict();
  end

  initial begin
    rx = '0;
    cmd = '0;
    void'($urandom(52));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(hfb_pkg::OFF_LEVEL);
    `CHK(r, 32'h0)
    rd(hfb_pkg::OFF_THRESH);
    `CHK(r, 32'h8)
    rd(hfb_pkg::OFF_STATUS);
    `CHK(r, 32'h1)
    foreach (zaddr[i]) begin
      rd(zaddr[i]);
      `CHK(r, 32'h0)
    end
    rd(8'h28);
    `CHK({e, r}, 33'h100000000)
    $display("test reset values done");
    // fill to full with garbage in the upper bits, alerts checked each step
    th = 1 + $urandom % 20;
    wr(hfb_pkg::OFF_THRESH, 32'(th));
    wr(hfb_pkg::OFF_IRQ_EN, 32'h2);
    for (int k = 1; k <= 64; k++) begin
      r = $urandom;
      q.push_back(r[7:0]);
      wr(hfb_pkg::OFF_DATA, r);
      rd(hfb_pkg::OFF_STATUS);
      `CHK(r[1:0], alerts(k, th))
    end
    wr(hfb_pkg::OFF_DATA, 32'ha5);
    rd(hfb_pkg::OFF_ERROR);
    `CHK(r[0], 1'b1)
    `CHK(irq, 1'b1)
    rd(hfb_pkg::OFF_IRQ_FLAG);
    `CHK(r[2:0], 3'h6)
    wr(hfb_pkg::OFF_IRQ_FLAG, 32'h7);
    wr(hfb_pkg::OFF_IRQ_EN, 32'h1);
    rd(hfb_pkg::OFF_LEVEL);
    `CHK(irq, 1'b0)
    drain();
    `CHK(irq, 1'b1)
    rd(hfb_pkg::OFF_DATA);
    `CHK(r, 32'h0)
    rd(hfb_pkg::OFF_LEVEL);
    `CHK(r[6:0], 7'h0)
    wr(hfb_pkg::OFF_ERROR, 32'hff);
    wr(hfb_pkg::OFF_DATA, 32'h11);
    rd(hfb_pkg::OFF_ERROR);
    `CHK(r[0], 1'b1)
    wr(hfb_pkg::OFF_LEVEL, 32'h80);
    rd(hfb_pkg::OFF_ERROR);
    `CHK(r[0], 1'b0)
    rd(hfb_pkg::OFF_LEVEL);
    `CHK(r[6:0], 7'h0)
    wr(hfb_pkg::OFF_IRQ_EN, 32'h0);
    $display("test host fill and drain done");
    // continuous receive, window 16..19, rejects on both edges
    wr(hfb_pkg::OFF_LEN_LOW, 32'h4);
    wr(hfb_pkg::OFF_LEN_HIGH, 32'h5);
    wr(hfb_pkg::OFF_RX_MODE, 32'h3);
    lens = '{15, 16, 19, 20, 16 + $urandom % 4};
    foreach (lens[i]) pkt(lens[i], lens[i], 7'($urandom), acc(lens[i], 4, 5), 1'b1);
    `CHK(rx_active, 1'b1)
    drain();
    $display("test continuous receive done");
    // single packet mode, max field zero means no upper bound below 256
    wr(hfb_pkg::OFF_LEN_LOW, 32'h9);
    wr(hfb_pkg::OFF_LEN_HIGH, 32'h0);
    wr(hfb_pkg::OFF_RX_MODE, 32'h1);
    pkt(8, 8, 7'h0, acc(8, 9, 0), 1'b0);
    `CHK(rx_active, 1'b1)
    pkt(36, 36, 7'h0, acc(36, 9, 0), 1'b0);
    `CHK(rx_active, 1'b0)
    pkt(40, 4, 7'h0, 1'b0, 1'b0);
    drain();
    $display("test single packet receive done");
    // received data beyond capacity is lost
    wr(hfb_pkg::OFF_LEN_LOW, 32'h0);
    wr(hfb_pkg::OFF_RX_MODE, 32'h3);
    repeat (3) pkt(30, 30, 7'h0, 1'b1, 1'b1);
    rd(hfb_pkg::OFF_ERROR);
    `CHK(r[0], 1'b1)
    drain();
    wr(hfb_pkg::OFF_RX_MODE, 32'h0);
    wr(hfb_pkg::OFF_LEVEL, 32'h80);
    $display("test receive overflow done");
    // internal command side shares the same buffer
    @(posedge clk) cmd <= {1'b1, 1'b0, 8'h3c};
    @(posedge clk) cmd <= {1'b0, 1'b1, 8'h00};
    @(posedge clk) cmd <= '0;
    #1;
    `CHK(cmd_rvalid, 1'b1)
    `CHK(cmd_rdata, 8'h3c)
    @(posedge clk) cmd <= {1'b1, 1'b0, 8'h5a};
    @(posedge clk) cmd <= '0;
    rd(hfb_pkg::OFF_DATA);
    `CHK(r, 32'h5a)
    $display("test command access done");
    print_verdict();
  end
endmodule : hfb_fifo_tb
`default_nettype wire

/* tb/hfb_host_model.sv */
// host controller model: apb master for the fifo registers
`timescale 1ns/1ps
`default_nettype none
module hfb_host_model (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  // callers issue transfers only between internal command bursts
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    // no fixed latency assumed; the bench watchdog ends a hang
    while (pready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata_i;
    er = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released bus shows inverted values so stale data cannot pass
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask : xfer
endmodule : hfb_host_model
`default_nettype wire
